// *** verilog/vsp_pkg.sv ***
// Purpose: Shared constants and types of the video stream port shell
// Assumes: One clock, fixed build-time configuration, no control port
// Notes:   Component width 10 bits, 4:4:4 in, 4:2:2 or 4:2:0 out
`default_nettype none

package vsp_pkg;

    // ========================================================
    // Data layout
    localparam int COMP_W = 10;
    localparam int IN_W = 32;
    localparam int OUT_W = 24;
    localparam int IN_Y_LSB = 0;
    localparam int IN_CB_LSB = 10;
    localparam int IN_CR_LSB = 20;
    localparam int OUT_Y_LSB = 0;
    localparam int OUT_C_LSB = 10;
    localparam int OUT_USED_W = 20;

    // ========================================================
    // Formats
    typedef enum logic [1:0] {
        VSP_FMT_444,
        VSP_FMT_422,
        VSP_FMT_420
    } vsp_fmt_t;

    localparam vsp_fmt_t OUT_FMT = VSP_FMT_420;

    // ========================================================
    // Fixed encoding word, laid out as the programmable one would be
    localparam logic [31:0] ENC_OFFSET = 32'h0000_0028;
    localparam int ENC_FIELD_BIT = 7;
    localparam int ENC_CHROMA_BIT = 8;
    localparam logic [31:0] ENC_VALUE = 32'h0000_0100;
    localparam bit HAS_CTRL_PORT = 1'b0;
    localparam bit HAS_IRQ_BUS = 1'b0;

    // ========================================================
    // Reset values
    localparam logic [1:0] CNT_RST = 2'h0;
    localparam logic PHASE_RST = 1'h0;
    localparam logic LINE_CHROMA_RST = 1'h1;

endpackage : vsp_pkg

`default_nettype wire

// *** verilog/vsp_stream_shell.sv ***
// Purpose: Stream port shell: 4:4:4 input repacked as 4:2:2 or 4:2:0
// Assumes: Upstream keeps its offered beat stable until taken
// Notes:   Two-entry buffer between input and output ports
`default_nettype none

module vsp_stream_shell
    import vsp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic core_clock_gate,
    input wire logic [IN_W-1:0] s_axis_video_tdata,
    input wire logic s_axis_video_tvalid,
    output logic s_axis_video_tready,
    input wire logic s_axis_video_tuser,
    input wire logic s_axis_video_tlast,
    output logic [OUT_W-1:0] m_axis_video_tdata,
    output logic m_axis_video_tvalid,
    input wire logic m_axis_video_tready,
    output logic m_axis_video_tuser,
    output logic m_axis_video_tlast,
    output logic field_parity
);

    // ========================================================
    // State
    typedef struct packed {
        logic [OUT_W-1:0] data0;
        logic [OUT_W-1:0] data1;
        logic sof0;
        logic sof1;
        logic eol0;
        logic eol1;
        logic [1:0] cnt;
        logic phase;
        logic line_chroma;
    } vsp_state_t;

    vsp_state_t st;
    vsp_state_t next_st;

    logic push;
    logic pop;
    logic eff_phase;
    logic eff_line_chroma;
    logic [COMP_W-1:0] in_y;
    logic [COMP_W-1:0] in_cb;
    logic [COMP_W-1:0] in_cr;
    logic [COMP_W-1:0] out_c;
    logic [OUT_W-1:0] packed_word;

    // Settings fixed at build time; no control port or irq bus built
    localparam logic CHROMA_FIRST = ENC_VALUE[ENC_CHROMA_BIT];
    localparam logic FIELD_FIXED = ENC_VALUE[ENC_FIELD_BIT];
    // No register slave, response channels or irq pins in this build

    // ========================================================
    // Handshake
    // Ready comes from registered count only, so it holds while frozen
    assign s_axis_video_tready = (st.cnt != 2'h2);
    assign m_axis_video_tvalid = (st.cnt != CNT_RST);
    // Only taken beats count, so idle cycles never carry samples
    assign push = s_axis_video_tvalid && s_axis_video_tready
        && core_clock_gate;
    assign pop = m_axis_video_tvalid && m_axis_video_tready
        && core_clock_gate;

    assign m_axis_video_tdata = st.data0;
    assign m_axis_video_tuser = st.sof0;
    assign m_axis_video_tlast = st.eol0;
    assign field_parity = FIELD_FIXED;

    // ========================================================
    // Repacking
    always_comb begin
        // Input beat holds all three components at once
        in_y = s_axis_video_tdata[IN_Y_LSB +: COMP_W];
        in_cb = s_axis_video_tdata[IN_CB_LSB +: COMP_W];
        in_cr = s_axis_video_tdata[IN_CR_LSB +: COMP_W];
        // Frame start restarts line and chroma phase
        eff_phase = s_axis_video_tuser ? PHASE_RST : st.phase;
        eff_line_chroma = s_axis_video_tuser ? CHROMA_FIRST
            : st.line_chroma;
        out_c = eff_phase ? in_cr : in_cb;
        // Lines without chroma carry zero in the chroma slot
        if (OUT_FMT == VSP_FMT_420 && !eff_line_chroma) begin
            out_c = '0;
        end
        packed_word = '0;
        packed_word[OUT_Y_LSB +: COMP_W] = in_y;
        packed_word[OUT_C_LSB +: COMP_W] = out_c;
    end

    // ========================================================
    // Next state
    always_comb begin
        next_st = st;
        if (push) begin
            if (s_axis_video_tlast) begin
                next_st.phase = PHASE_RST;
                next_st.line_chroma = (OUT_FMT == VSP_FMT_420)
                    ? !eff_line_chroma : LINE_CHROMA_RST;
            end else begin
                next_st.phase = !eff_phase;
                next_st.line_chroma = eff_line_chroma;
            end
        end
        // Head always in slot 0 so output data comes straight from a flop
        case (st.cnt)
            2'h0: begin
                if (push) begin
                    next_st.data0 = packed_word;
                    next_st.sof0 = s_axis_video_tuser;
                    next_st.eol0 = s_axis_video_tlast;
                    next_st.cnt = 2'h1;
                end
            end
            2'h1: begin
                if (push && pop) begin
                    next_st.data0 = packed_word;
                    next_st.sof0 = s_axis_video_tuser;
                    next_st.eol0 = s_axis_video_tlast;
                end else if (pop) begin
                    next_st.cnt = 2'h0;
                end else if (push) begin
                    next_st.data1 = packed_word;
                    next_st.sof1 = s_axis_video_tuser;
                    next_st.eol1 = s_axis_video_tlast;
                    next_st.cnt = 2'h2;
                end
            end
            2'h2: begin
                if (pop) begin
                    next_st.data0 = st.data1;
                    next_st.sof0 = st.sof1;
                    next_st.eol0 = st.eol1;
                    next_st.cnt = 2'h1;
                end
            end
            default: begin
                next_st.cnt = CNT_RST;
            end
        endcase
        if (!core_clock_gate) begin
            next_st = st;
        end
    end

    // ========================================================
    // Registers
    // Reset checked first, so it wins over a low clock gate
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st <= '0;
            st.cnt <= CNT_RST;
            st.phase <= PHASE_RST;
            st.line_chroma <= LINE_CHROMA_RST;
        end else begin
            st <= next_st;
        end
    end

endmodule // vsp_stream_shell

`default_nettype wire

// *** tb/vsp_stream_shell_asserts.sv ***
// Purpose: Port checks for the stream shell
// Assumes: Bound onto vsp_stream_shell
// Notes:   Sees top ports only
`default_nettype none
module vsp_stream_shell_asserts
    import vsp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic core_clock_gate,
    input wire logic s_axis_video_tvalid,
    input wire logic s_axis_video_tready,
    input wire logic [OUT_W-1:0] m_axis_video_tdata,
    input wire logic m_axis_video_tvalid,
    input wire logic m_axis_video_tready,
    input wire logic m_axis_video_tuser
);
    timeunit 1ns;
    timeprecision 1ps;
    wire logic gt = core_clock_gate;
    wire logic sv = s_axis_video_tvalid;
    wire logic sr = s_axis_video_tready;
    wire logic mv = m_axis_video_tvalid;
    wire logic mr = m_axis_video_tready;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    // ====
    // Checks
    property p_hold;
        mv && !mr |=> mv && $stable(m_axis_video_tdata);
    endproperty
    a_hold: assert property (p_hold) else $error("beat moved");
    property p_gate; !gt |=> $stable({mv, sr, m_axis_video_tuser}); endproperty
    a_gate: assert property (p_gate) else $error("gate");
    property p_pad; mv |-> m_axis_video_tdata[OUT_W-1:OUT_USED_W] == '0;
    endproperty
    a_pad: assert property (p_pad) else $error("pad");
    property p_rst; disable iff (1'b0) srst |=> !mv && sr; endproperty
    a_rst: assert property (p_rst) else $error("reset");
    property p_fill; gt && sv && sr && !mv |=> mv; endproperty
    a_fill: assert property (p_fill) else $error("fill");
    property p_ign; !gt && !mv |=> !mv; endproperty
    a_ign: assert property (p_ign) else $error("ignore");
    property p_full; !sr && !(mr && gt) |=> !sr; endproperty
    a_full: assert property (p_full) else $error("full");
    property p_free; !sr && mr && gt |=> sr && mv; endproperty
    a_free: assert property (p_free) else $error("free");
endmodule // vsp_stream_shell_asserts
`default_nettype wire

// *** tb/vsp_sink_model.sv ***
// Purpose: Downstream sink model
// Assumes: Ready changes at the falling edge
// Notes:   Slow mode takes every other cycle
`default_nettype none
module vsp_sink_model
    import vsp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic core_clock_gate,
    input wire logic hold,
    input wire logic slow,
    input wire logic tvalid,
    input wire logic tuser,
    input wire logic tlast,
    input wire logic [OUT_W-1:0] tdata,
    output logic tready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [OUT_W+1:0] q[$];
    logic ph = 1'b0;
    initial tready = 1'b0;
    // Ready not tied to valid
    always @(negedge sys_clk) begin
        ph <= !ph;
        tready <= !hold && (!slow || ph);
    end
    // Beat taken only with gate high
    always @(posedge sys_clk) begin
        if (tready && tvalid && core_clock_gate) begin
            q.push_back({tuser, tlast, tdata});
        end
    end
endmodule // vsp_sink_model
`default_nettype wire

// *** tb/vsp_stream_shell_tb.sv ***
// Purpose: Self-checking bench for the stream shell
// Assumes: 4:2:0 out, chroma on first line
// Notes:   Inputs change on the falling edge
`default_nettype none
module vsp_stream_shell_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import vsp_pkg::*;
    typedef struct packed {
        logic [IN_W-1:0] din;
        logic sof, line_end_flag;
        logic [OUT_W-1:0] dout;
    } vsp_row_t;
    // Inputs keep bits 31:30 zero as the padding demands
    vsp_row_t rows [6] = '{'{32'h02104401, 1, 0, 24'h004401},
        '{32'h02204802, 0, 0, 24'h008802}, '{32'h02304c03, 0, 1, 24'h004c03},
        '{32'h02404004, 0, 0, 24'h000004}, '{32'h02504005, 0, 0, 24'h000005},
        '{32'h02604006, 0, 1, 24'h000006}};
    logic sys_clk = 1'b0, srst = 1'b1, gate = 1'b1, hold = 1'b0, slow = 1'b0;
    logic sv = 1'b0, su = 1'b0, sl = 1'b0, sr, mv, mr, mu, ml, fp;
    logic [IN_W-1:0] sd = '0;
    logic [OUT_W-1:0] md;
    int errors = 0, checked = 0, cyc = 0;
    always #4 sys_clk = ~sys_clk;
    vsp_stream_shell vsp_stream_shell_inst (.sys_clk, .srst,
        .core_clock_gate(gate), .s_axis_video_tdata(sd),
        .s_axis_video_tvalid(sv), .s_axis_video_tready(sr),
        .s_axis_video_tuser(su), .s_axis_video_tlast(sl),
        .m_axis_video_tdata(md), .m_axis_video_tvalid(mv),
        .m_axis_video_tready(mr), .m_axis_video_tuser(mu),
        .m_axis_video_tlast(ml), .field_parity(fp));
    vsp_sink_model vsp_sink_model_inst (.sys_clk, .core_clock_gate(gate),
        .hold, .slow, .tvalid(mv), .tuser(mu), .tlast(ml), .tdata(md),
        .tready(mr));
    task automatic check(input logic [OUT_W+1:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Offer held unchanged until ready is seen high at a falling edge, then for one more cycle
    task automatic send(input vsp_row_t r);
        sd = r.din;
        su = r.sof;
        sl = r.line_end_flag;
        sv = 1'b1;
        while (!sr) @(negedge sys_clk);
        @(negedge sys_clk);
    endtask
    task automatic drain(input int n, base);
        sv = 1'b0;
        while (vsp_sink_model_inst.q.size() < n) @(negedge sys_clk);
        for (int i = base; i < n; i++) check(vsp_sink_model_inst.q[i],
            {rows[i-base].sof, rows[i-base].line_end_flag, rows[i-base].dout});
    endtask
    task automatic summarize();
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 2000) begin
            errors++;
            summarize();
        end
    end
    initial begin
        repeat (6) @(negedge sys_clk);
        srst = 1'b0;
        check({sr, mv}, 2'b10);
        check(fp, ENC_VALUE[ENC_FIELD_BIT]);
        slow = 1'b1;
        foreach (rows[i]) send(rows[i]);
        drain(6, 0);
        slow = 1'b0;
        hold = 1'b1;
        send(rows[0]);
        send(rows[1]);
        check(sr, 1'b0);
        gate = 1'b0;
        hold = 1'b0;
        repeat (3) @(negedge sys_clk);
        check(vsp_sink_model_inst.q.size(), 6);
        gate = 1'b1;
        send(rows[2]);
        drain(9, 6);
        gate = 1'b0;
        srst = 1'b1;
        send(rows[3]);
        srst = 1'b0;
        check({sr, mv}, 2'b10);
        summarize();
    end
endmodule // vsp_stream_shell_tb
bind vsp_stream_shell vsp_stream_shell_asserts
    vsp_stream_shell_asserts_inst (.*);
`default_nettype wire
